// [shared/bbfd_pkg.sv]
/*
 * constants for the byte/bit file-operation decoder: opcode fields, opcode
 * nibbles, status flag positions and reset values.
 * assumes a 14-bit instruction word and a 7-bit file address.
 */
`default_nettype none
package bbfd_pkg;
    // instruction word layout
    localparam int BBFD_INSTR_W = 14;
    localparam int BBFD_CLASS_MSB = 13;
    localparam int BBFD_CLASS_LSB = 12;
    localparam int BBFD_OP_MSB = 11;
    localparam int BBFD_OP_LSB = 8;
    localparam int BBFD_DEST_BIT = 7;
    localparam int BBFD_ADDR_MSB = 6;
    localparam int BBFD_BITOP_MSB = 11;
    localparam int BBFD_BITOP_LSB = 10;
    localparam int BBFD_BIDX_MSB = 9;
    localparam int BBFD_BIDX_LSB = 7;
    // instruction classes (top two bits)
    localparam logic [1:0] BBFD_CLS_BYTE = 2'h0;
    localparam logic [1:0] BBFD_CLS_BIT = 2'h1;
    // byte-oriented opcode nibbles
    localparam logic [3:0] BBFD_OP_MOVE_TO = 4'h0;
    localparam logic [3:0] BBFD_OP_CLEAR = 4'h1;
    localparam logic [3:0] BBFD_OP_SUB = 4'h2;
    localparam logic [3:0] BBFD_OP_DEC = 4'h3;
    localparam logic [3:0] BBFD_OP_IOR = 4'h4;
    localparam logic [3:0] BBFD_OP_AND = 4'h5;
    localparam logic [3:0] BBFD_OP_XOR = 4'h6;
    localparam logic [3:0] BBFD_OP_ADD = 4'h7;
    localparam logic [3:0] BBFD_OP_MOVE = 4'h8;
    localparam logic [3:0] BBFD_OP_COMP = 4'h9;
    localparam logic [3:0] BBFD_OP_INC = 4'ha;
    localparam logic [3:0] BBFD_OP_DECSZ = 4'hb;
    localparam logic [3:0] BBFD_OP_RRC = 4'hc;
    localparam logic [3:0] BBFD_OP_RLC = 4'hd;
    localparam logic [3:0] BBFD_OP_SWAP = 4'he;
    localparam logic [3:0] BBFD_OP_INCSZ = 4'hf;
    // bit-oriented sub-opcodes
    localparam logic [1:0] BBFD_BOP_CLR = 2'h0;
    localparam logic [1:0] BBFD_BOP_SET = 2'h1;
    localparam logic [1:0] BBFD_BOP_TSTC = 2'h2;
    localparam logic [1:0] BBFD_BOP_TSTS = 2'h3;
    // status flag positions inside the 3-bit flag vector
    localparam int BBFD_FLG_C = 0;
    localparam int BBFD_FLG_DC = 1;
    localparam int BBFD_FLG_Z = 2;
    // reset values
    localparam logic [7:0] BBFD_ACC_RST = 8'h00;
    localparam logic [2:0] BBFD_FLG_RST = 3'h0;
endpackage : bbfd_pkg
`default_nettype wire

// [design/bbfd_alu.sv]
/*
 * combinational alu for the byte/bit file operations: result, new flags,
 * flag-update mask and skip decision for one instruction word.
 * assumes the operand already holds pin levels for port registers.
 */
`timescale 1ns/1ps
`default_nettype none
module bbfd_alu
    import bbfd_pkg::*;
(
    // instruction and operands
    input wire logic [13:0] instr,
    input wire logic [7:0] acc,
    input wire logic [7:0] file_val,
    input wire logic carry_in,
    // results
    output logic [7:0] result,
    output logic [2:0] flags,
    output logic [2:0] flag_upd,
    output logic wr_file,
    output logic wr_acc,
    output logic skip
);
    logic [1:0] cls; // instruction class
    logic [3:0] op; // byte opcode nibble
    logic [1:0] bop; // bit opcode
    logic [2:0] bidx; // bit index
    logic [8:0] sum9; // 9-bit sum for carry
    logic [4:0] sum5; // low nibble sum for half carry
    logic dest_file; // destination select

    assign cls = instr[BBFD_CLASS_MSB:BBFD_CLASS_LSB];
    assign op = instr[BBFD_OP_MSB:BBFD_OP_LSB];
    assign bop = instr[BBFD_BITOP_MSB:BBFD_BITOP_LSB];
    assign bidx = instr[BBFD_BIDX_MSB:BBFD_BIDX_LSB];
    assign dest_file = instr[BBFD_DEST_BIT];

    // decode and compute in one pass
    always_comb
    begin
        result = file_val;
        flags = 3'h0;
        flag_upd = 3'h0;
        wr_file = 1'b0;
        wr_acc = 1'b0;
        skip = 1'b0;
        sum9 = 9'h000;
        sum5 = 5'h00;
        if (cls == BBFD_CLS_BYTE)
        begin
            // bit 7 picks file or accumulator
            wr_file = dest_file;
            wr_acc = ~dest_file;
            case (op)
                BBFD_OP_MOVE_TO:
                begin
                    // move acc to file writes the file only when bit 7 is set; low pattern is a no-op
                    result = acc;
                    wr_file = dest_file;
                    wr_acc = 1'b0;
                end
                BBFD_OP_CLEAR:
                begin
                    result = 8'h00;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                // add and subtract touch c, dc, z
                BBFD_OP_ADD:
                begin
                    sum9 = {1'b0, file_val} + {1'b0, acc};
                    sum5 = {1'b0, file_val[3:0]} + {1'b0, acc[3:0]};
                    result = sum9[7:0];
                    flags[BBFD_FLG_C] = sum9[8];
                    flags[BBFD_FLG_DC] = sum5[4];
                    flag_upd = 3'h7;
                end
                BBFD_OP_SUB:
                begin
                    // two's complement add; carry set means no borrow
                    sum9 = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
                    sum5 = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                    result = sum9[7:0];
                    flags[BBFD_FLG_C] = sum9[8];
                    flags[BBFD_FLG_DC] = sum5[4];
                    flag_upd = 3'h7;
                end
                BBFD_OP_XOR:
                begin
                    result = file_val ^ acc;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                // or, and, complement touch only z
                BBFD_OP_IOR:
                begin
                    result = file_val | acc;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_AND:
                begin
                    result = file_val & acc;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_COMP:
                begin
                    result = ~file_val;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_DEC:
                begin
                    result = file_val - 8'h01;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_INC:
                begin
                    result = file_val + 8'h01;
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_MOVE:
                begin
                    flag_upd[BBFD_FLG_Z] = 1'b1;
                end
                BBFD_OP_SWAP:
                begin
                    result = {file_val[3:0], file_val[7:4]};
                end
                // decrement, skip on zero, no flags
                BBFD_OP_DECSZ:
                begin
                    result = file_val - 8'h01;
                    skip = (result == 8'h00);
                end
                // increment, skip on zero, no flags
                BBFD_OP_INCSZ:
                begin
                    result = file_val + 8'h01;
                    skip = (result == 8'h00);
                end
                BBFD_OP_RRC:
                begin
                    result = {carry_in, file_val[7:1]};
                    flags[BBFD_FLG_C] = file_val[0];
                    flag_upd[BBFD_FLG_C] = 1'b1;
                end
                BBFD_OP_RLC:
                begin
                    result = {file_val[6:0], carry_in};
                    flags[BBFD_FLG_C] = file_val[7];
                    flag_upd[BBFD_FLG_C] = 1'b1;
                end
                default:
                begin
                    wr_file = 1'b0;
                    wr_acc = 1'b0;
                end
            endcase
            flags[BBFD_FLG_Z] = (result == 8'h00);
        end
        else if (cls == BBFD_CLS_BIT)
        begin
            case (bop)
                // clear or set one bit, no flags
                BBFD_BOP_CLR:
                begin
                    result[bidx] = 1'b0;
                    wr_file = 1'b1;
                end
                BBFD_BOP_SET:
                begin
                    result[bidx] = 1'b1;
                    wr_file = 1'b1;
                end
                BBFD_BOP_TSTC:
                    skip = ~file_val[bidx];
                BBFD_BOP_TSTS:
                    skip = file_val[bidx];
                default:
                    skip = 1'b0;
            endcase
        end
    end
endmodule : bbfd_alu
`default_nettype wire

// [design/bbfd_decoder.sv]
/*
 * executes byte- and bit-oriented file instructions, one per instruction
 * cycle, owns the accumulator and the c/dc/z flags, and inserts a no-op
 * cycle after a taken skip.
 * assumes a fetch stage that offers one word per cycle with a valid strobe,
 * a file memory read combinationally at file_addr, and port pin levels
 * already synchronised by the port block.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - rotate left through carry, only carry
// - rotate right through carry, only carry
// - add/subtract set c,dc,z; xor only z
// - or, and, complement change only z
// - decrement, skip if zero, no flags
// - increment, skip if zero, no flags
// - bit test skips when bit clear
// - bit test skips when bit set
// - skip costs second cycle as no-op
// - port read-modify-write uses pin levels
// - timer write clears its assigned prescaler
module bbfd_decoder
    import bbfd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // fetch stage
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    output logic instr_ready,
    output logic skip_next,
    // file memory
    output logic [6:0] file_addr,
    input wire logic [7:0] file_rdata,
    output logic file_we,
    output logic [7:0] file_wdata,
    // port pins and timer
    input wire logic addr_is_port,
    input wire logic [7:0] port_pins,
    input wire logic addr_is_timer,
    input wire logic prescaler_on_timer,
    output logic prescaler_clr,
    // core state
    output logic [7:0] acc_out,
    output logic carry_out,
    output logic half_carry_flag,
    output logic zero_out
);
    typedef enum logic {BBFD_EXEC, BBFD_NOP} bbfd_state_t;

    bbfd_state_t state_ff; // execute or dummy cycle
    bbfd_state_t nxt_state;
    logic [7:0] acc_ff; // working accumulator
    logic [2:0] flags_ff; // c, dc, z
    logic [2:0] nxt_flags;
    logic file_we_ff; // registered write strobe
    logic [7:0] file_wdata_ff; // registered write data
    logic [6:0] wr_addr_ff; // address of pending write
    logic presc_clr_ff; // registered prescaler clear
    logic [7:0] operand; // file value or pins
    logic [7:0] alu_res;
    logic [2:0] alu_flags;
    logic [2:0] alu_upd;
    logic alu_wr_file;
    logic alu_wr_acc;
    logic alu_skip;
    logic take; // an instruction executes this cycle

    // low seven bits address the file
    assign file_addr = instr[BBFD_ADDR_MSB:0];
    // the dummy cycle swallows the skipped word
    assign instr_ready = 1'b1;
    assign take = instr_valid && (state_ff == BBFD_EXEC);

    // ports read pins, not the latch
    assign operand = addr_is_port ? port_pins : file_rdata;

    bbfd_alu u_alu (
        .instr(instr),
        .acc(acc_ff),
        .file_val(operand),
        .carry_in(flags_ff[BBFD_FLG_C]),
        .result(alu_res),
        .flags(alu_flags),
        .flag_upd(alu_upd),
        .wr_file(alu_wr_file),
        .wr_acc(alu_wr_acc),
        .skip(alu_skip)
    );

    // a taken skip forces one no-op cycle
    always_comb
    begin
        nxt_state = BBFD_EXEC;
        case (state_ff)
            BBFD_EXEC: nxt_state = (take && alu_skip) ? BBFD_NOP : BBFD_EXEC;
            BBFD_NOP: nxt_state = BBFD_EXEC;
            default: nxt_state = BBFD_EXEC;
        endcase
    end

    // sequencing state
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            state_ff <= BBFD_EXEC;
        else
            state_ff <= nxt_state;
    end

    assign skip_next = (state_ff == BBFD_NOP);

    // accumulator update; nothing changes during the no-op cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            acc_ff <= BBFD_ACC_RST;
        else if (take && alu_wr_acc)
            acc_ff <= alu_res;
    end

    // merge only the flags this opcode owns
    always_comb
    begin
        nxt_flags = flags_ff;
        if (take)
            nxt_flags = (flags_ff & ~alu_upd) | (alu_flags & alu_upd);
    end

    // status flags
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flags_ff <= BBFD_FLG_RST;
        else
            flags_ff <= nxt_flags;
    end

    // file write port; registered so data comes from flip-flops
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            file_we_ff <= 1'b0;
            file_wdata_ff <= 8'h00;
            wr_addr_ff <= 7'h00;
        end
        else
        begin
            file_we_ff <= take && alu_wr_file;
            file_wdata_ff <= alu_res;
            wr_addr_ff <= file_addr;
        end
    end

    // writing the timer clears its prescaler
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            presc_clr_ff <= 1'b0;
        else
            presc_clr_ff <= take && alu_wr_file && addr_is_timer && prescaler_on_timer;
    end

    assign file_we = file_we_ff;
    assign file_wdata = file_wdata_ff;
    assign prescaler_clr = presc_clr_ff;
    assign acc_out = acc_ff;
    assign carry_out = flags_ff[BBFD_FLG_C];
    assign half_carry_flag = flags_ff[BBFD_FLG_DC];
    assign zero_out = flags_ff[BBFD_FLG_Z];

    // checks: the write address is tracked for the assertions only
    // one dummy cycle, then straight back to execution
    sequence bbfd_one_nop_s;
        skip_next ##1 !skip_next;
    endsequence
    // skip yields exactly one no-op cycle
    AST_SKIP_NOP: assert property (@(posedge clk_sys) disable iff (reset)
        (take && alu_skip) |=> bbfd_one_nop_s)
        else $error("skip did not give one no-op cycle");
    AST_SKIPOP_FLAGS: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:12] == BBFD_CLS_BYTE && (instr[11:8] == BBFD_OP_DECSZ || instr[11:8] == BBFD_OP_INCSZ))
        |=> $stable(flags_ff))
        else $error("skip-on-zero op changed a flag");
    AST_NOP_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
        skip_next |=> !file_we && $stable(acc_ff) && $stable(flags_ff))
        else $error("no-op cycle changed state");
    AST_RLC_CARRY: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:8] == {BBFD_CLS_BYTE, BBFD_OP_RLC})
        |=> carry_out == $past(operand[7]) && zero_out == $past(flags_ff[BBFD_FLG_Z]))
        else $error("rotate left carry wrong");
    AST_RRC_CARRY: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:8] == {BBFD_CLS_BYTE, BBFD_OP_RRC})
        |=> carry_out == $past(operand[0]) && half_carry_flag == $past(flags_ff[BBFD_FLG_DC]))
        else $error("rotate right carry wrong");
    AST_XOR_ZONLY: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:8] == {BBFD_CLS_BYTE, BBFD_OP_XOR})
        |=> $stable(carry_out) && zero_out == ($past(operand ^ acc_ff) == 8'h00))
        else $error("xor flag update wrong");
    AST_AND_ZONLY: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:8] == {BBFD_CLS_BYTE, BBFD_OP_AND}) |=> $stable(carry_out))
        else $error("and changed carry");
    AST_DEST: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:12] == BBFD_CLS_BYTE && instr[11:8] != BBFD_OP_MOVE_TO && instr[7])
        |=> file_we && wr_addr_ff == $past(instr[6:0]) && $stable(acc_ff))
        else $error("destination select wrong");
    AST_BITSET: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:10] == {BBFD_CLS_BIT, BBFD_BOP_SET})
        |=> file_we && file_wdata[$past(instr[9:7])] && $stable(flags_ff))
        else $error("bit set wrong");
    // timer write clears prescaler; decoded from the word itself
    AST_TMR_PRESC: assert property (@(posedge clk_sys) disable iff (reset)
        (take && addr_is_timer && prescaler_on_timer
            && ((instr[13:12] == BBFD_CLS_BYTE && instr[7]) || instr[13:11] == {BBFD_CLS_BIT, 1'b0}))
        |=> prescaler_clr)
        else $error("prescaler not cleared");
    AST_BTST_C: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:10] == {BBFD_CLS_BIT, BBFD_BOP_TSTC} && !operand[instr[9:7]]) |=> skip_next)
        else $error("bit test clear did not skip");
    AST_BTST_S: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:10] == {BBFD_CLS_BIT, BBFD_BOP_TSTS} && !operand[instr[9:7]]) |=> !skip_next)
        else $error("bit test set skipped wrongly");
    AST_BTST_S_HIT: assert property (@(posedge clk_sys) disable iff (reset)
        (take && instr[13:10] == {BBFD_CLS_BIT, BBFD_BOP_TSTS} && operand[instr[9:7]]) |=> skip_next)
        else $error("bit test set did not skip");
    AST_PORT_PINS: assert property (@(posedge clk_sys) disable iff (reset)
        (take && addr_is_port && instr[13:8] == {BBFD_CLS_BYTE, BBFD_OP_IOR} && instr[7])
        |=> file_wdata == ($past(port_pins) | $past(acc_ff)))
        else $error("port op did not use pin levels");
endmodule : bbfd_decoder
`default_nettype wire

// [testbench/tb_byte_bit_file_op_decoder.sv]
/*
 * self-checking bench for the byte/bit file-operation decoder: corner cases
 * first, then seeded random words, all checked against a bench-side model.
 * assumes the decoder executes one word per cycle and registers its writes.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_byte_bit_file_op_decoder;
    import bbfd_pkg::*;
    // clock, reset and design ports
    logic clk_sys;
    logic reset;
    logic instr_valid;
    logic [13:0] instr;
    logic instr_ready;
    logic skip_next;
    logic [6:0] file_addr;
    logic [7:0] file_rdata;
    logic file_we;
    logic [7:0] file_wdata;
    logic addr_is_port;
    logic [7:0] port_pins;
    logic addr_is_timer;
    logic prescaler_on_timer;
    logic prescaler_clr;
    logic [7:0] acc_out;
    logic carry_out;
    logic half_carry_flag;
    logic zero_out;
    // model state and expected pulses
    logic [7:0] m_acc;
    logic m_c;
    logic m_dc;
    logic m_z;
    logic e_we;
    logic e_pclr;
    logic e_skip;
    logic [7:0] e_wdata;
    int fails;
    int n_tests;
    int cyc;

    bbfd_decoder bbfd_decoder_i (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .skip_next(skip_next), .file_addr(file_addr), .file_rdata(file_rdata),
        .file_we(file_we), .file_wdata(file_wdata), .addr_is_port(addr_is_port), .port_pins(port_pins),
        .addr_is_timer(addr_is_timer), .prescaler_on_timer(prescaler_on_timer), .prescaler_clr(prescaler_clr),
        .acc_out(acc_out), .carry_out(carry_out), .half_carry_flag(half_carry_flag), .zero_out(zero_out));

    // 250 mhz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // verdict and end of run, shared by the main flow and the timeout
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // bench model of one executed word; opd already holds pins for ports
    function automatic void predict(input logic [13:0] w, input logic [7:0] opd);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic wf;
        logic wa;
        logic [2:0] b;
        wf = 1'b0;
        wa = 1'b0;
        e_skip = 1'b0;
        r = 8'h00;
        b = w[BBFD_BIDX_MSB:BBFD_BIDX_LSB];
        if (w[13:12] == BBFD_CLS_BYTE)
        begin
            wf = w[BBFD_DEST_BIT];
            wa = !w[BBFD_DEST_BIT];
            case (w[11:8])
                BBFD_OP_MOVE_TO: begin r = m_acc; wa = 1'b0; end
                BBFD_OP_CLEAR: r = 8'h00;
                BBFD_OP_SUB: begin r = opd - m_acc; m_c = (opd >= m_acc);
                    m_dc = (opd[3:0] >= m_acc[3:0]); end
                BBFD_OP_DEC: r = opd - 8'h01;
                BBFD_OP_IOR: r = opd | m_acc;
                BBFD_OP_AND: r = opd & m_acc;
                BBFD_OP_XOR: r = opd ^ m_acc;
                BBFD_OP_ADD: begin s = {1'b0, opd} + {1'b0, m_acc}; h = {1'b0, opd[3:0]} + {1'b0, m_acc[3:0]};
                    r = s[7:0]; m_c = s[8]; m_dc = h[4]; end
                BBFD_OP_MOVE: r = opd;
                BBFD_OP_COMP: r = ~opd;
                BBFD_OP_INC: r = opd + 8'h01;
                BBFD_OP_DECSZ: begin r = opd - 8'h01; e_skip = (r == 8'h00); end
                BBFD_OP_INCSZ: begin r = opd + 8'h01; e_skip = (r == 8'h00); end
                BBFD_OP_RRC: begin r = {m_c, opd[7:1]}; m_c = opd[0]; end
                BBFD_OP_RLC: begin r = {opd[6:0], m_c}; m_c = opd[7]; end
                default: r = {opd[3:0], opd[7:4]};
            endcase
            // zero flag only for these nibbles
            if (w[11:8] >= BBFD_OP_CLEAR && w[11:8] <= BBFD_OP_INC)
                m_z = (r == 8'h00);
        end
        else if (w[13:12] == BBFD_CLS_BIT)
        begin
            r = opd;
            case (w[BBFD_BITOP_MSB:BBFD_BITOP_LSB])
                BBFD_BOP_CLR: begin r[b] = 1'b0; wf = 1'b1; end
                BBFD_BOP_SET: begin r[b] = 1'b1; wf = 1'b1; end
                BBFD_BOP_TSTC: e_skip = !opd[b];
                default: e_skip = opd[b];
            endcase
        end
        if (wa)
            m_acc = r;
        e_we = wf;
        e_wdata = r;
        e_pclr = wf && addr_is_timer && prescaler_on_timer;
    endfunction : predict

    // accumulator and flags against the model
    task automatic chk_state();
        chk("acc", m_acc, acc_out);
        chk("carry", {7'h00, m_c}, {7'h00, carry_out});
        chk("half carry", {7'h00, m_dc}, {7'h00, half_carry_flag});
        chk("zero", {7'h00, m_z}, {7'h00, zero_out});
    endtask : chk_state

    // one word, entered and left at a falling edge
    task automatic run_one(input logic v, input logic [13:0] w, input logic [7:0] rd, input logic pt,
        input logic [7:0] pins, input logic tm, input logic pre);
        instr_valid = v;
        instr = w;
        file_rdata = rd;
        addr_is_port = pt;
        port_pins = pins;
        addr_is_timer = tm;
        prescaler_on_timer = pre;
        e_we = 1'b0;
        e_pclr = 1'b0;
        e_skip = 1'b0;
        // ports read the pins, not the latch
        if (v)
            predict(w, pt ? pins : rd);
        @(negedge clk_sys);
        chk("file addr", {1'b0, w[6:0]}, {1'b0, file_addr});
        chk("ready", 8'h01, {7'h00, instr_ready});
        chk_state();
        chk("file we", {7'h00, e_we}, {7'h00, file_we});
        if (e_we)
            chk("file wdata", e_wdata, file_wdata);
        chk("prescaler clr", {7'h00, e_pclr}, {7'h00, prescaler_clr});
        chk("skip", {7'h00, e_skip}, {7'h00, skip_next});
        if (e_skip)
        begin
            // a clear word that would write the file or the acc; it must be dropped
            instr_valid = 1'b1;
            instr = {2'b00, BBFD_OP_CLEAR, 1'($urandom), 7'h01};
            addr_is_timer = 1'b1;
            prescaler_on_timer = 1'b1;
            @(negedge clk_sys);
            chk_state();
            chk("no-op we", 8'h00, {7'h00, file_we});
            chk("no-op clr", 8'h00, {7'h00, prescaler_clr});
            chk("no-op skip", 8'h00, {7'h00, skip_next});
        end
    endtask : run_one

    // hang guard: well above the fewer than two thousand cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end

    // main sequence
    initial
    begin
        logic [13:0] w;
        fails = 0;
        n_tests = 0;
        cyc = 0;
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = 14'h0000;
        file_rdata = 8'h00;
        addr_is_port = 1'b0;
        port_pins = 8'h00;
        addr_is_timer = 1'b0;
        prescaler_on_timer = 1'b0;
        m_acc = BBFD_ACC_RST;
        {m_z, m_dc, m_c} = BBFD_FLG_RST;
        void'($urandom(28));
        repeat (20) @(negedge clk_sys);
        chk_state();
        chk("reset we", 8'h00, {7'h00, file_we});
        chk("reset skip", 8'h00, {7'h00, skip_next});
        reset = 1'b0;
        // hand-written corners, back to back
        run_one(1'b1, {2'b00, BBFD_OP_MOVE, 1'b0, 7'h10}, 8'hff, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_ADD, 1'b1, 7'h05}, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_RLC, 1'b0, 7'h06}, 8'h80, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_RRC, 1'b1, 7'h07}, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_SUB, 1'b0, 7'h08}, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_SUB, 1'b1, 7'h08}, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_XOR, 1'b0, 7'h09}, 8'h5a, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_COMP, 1'b1, 7'h0a}, 8'hff, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_DECSZ, 1'b1, 7'h0b}, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b00, BBFD_OP_INCSZ, 1'b0, 7'h0c}, 8'hff, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b01, BBFD_BOP_TSTC, 3'h3, 7'h0d}, 8'hf7, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b01, BBFD_BOP_TSTS, 3'h7, 7'h0d}, 8'h80, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b01, BBFD_BOP_TSTS, 3'h0, 7'h0d}, 8'hfe, 1'b0, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b01, BBFD_BOP_SET, 3'h2, 7'h06}, 8'hff, 1'b1, 8'h00, 1'b0, 1'b0);
        run_one(1'b1, {2'b01, BBFD_BOP_CLR, 3'h0, 7'h01}, 8'hff, 1'b0, 8'h00, 1'b1, 1'b1);
        run_one(1'b1, {2'b00, BBFD_OP_MOVE_TO, 1'b1, 7'h01}, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0);
        run_one(1'b1, {2'b11, 12'hfff}, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1);
        // seeded random words, mostly the two decoded classes
        repeat (1500)
        begin
            w = 14'($urandom);
            if ($urandom % 16 != 0)
                w[13] = 1'b0;
            run_one(($urandom % 8) != 0, w, 8'($urandom), ($urandom % 4) == 0, 8'($urandom),
                ($urandom % 4) == 0, 1'($urandom));
        end
        // second reset in mid-run; the core must restart from reset values
        reset = 1'b1;
        m_acc = BBFD_ACC_RST;
        {m_z, m_dc, m_c} = BBFD_FLG_RST;
        repeat (2) @(negedge clk_sys);
        chk_state();
        chk("reset we", 8'h00, {7'h00, file_we});
        chk("reset skip", 8'h00, {7'h00, skip_next});
        reset = 1'b0;
        run_one(1'b1, {2'b00, BBFD_OP_ADD, 1'b0, 7'h05}, 8'h80, 1'b0, 8'h00, 1'b0, 1'b0);
        close_out();
    end
endmodule : tb_byte_bit_file_op_decoder
`default_nettype wire
